// file: design/addr_match_defs.svh
// constants for the serial slave address front end
`ifndef ADDR_MATCH_DEFS_SVH
`define ADDR_MATCH_DEFS_SVH
`define BASE_SLAVE_ADDR 7'h42
`define LAST_SLAVE_ADDR 7'h49
`define ADDR_BITS 7
`define BYTE_BITS 4'h8
`define GLITCH_NS 50
`define CLK_PERIOD_NS 8
`define GLITCH_CYCLES ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: design/addr_match_pkg.sv
// types for the serial slave address front end
package addr_match_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_XFER = 3'b011,
        ST_SKIP = 3'b100
    } phase_type;
    typedef struct packed {
        logic dir_read;
        logic selected;
    } match_type;
    typedef struct packed {
        logic [2:0] strap;
    } strap_type;
endpackage : addr_match_pkg

// file: design/i2c_slave_address_match.sv
// address phase front end of a serial two-wire slave
`timescale 1ns/1ps
`include "addr_match_defs.svh"

module i2c_slave_address_match #(
    parameter int FILT_CYCLES = `GLITCH_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // address straps
    input wire addr_match_pkg::strap_type straps,
    // bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // status
    output addr_match_pkg::match_type match_ff,
    output logic busy_ff
);
    import addr_match_pkg::*;

    // refuse filter lengths the counter cannot hold
    if (FILT_CYCLES < 1 || FILT_CYCLES > 255) begin : g_filt_check
        $error("FILT_CYCLES out of range");
    end

    // ************************************************
    // synchronise and filter
    // ************************************************
    logic [2:0] scl_sync_ff, sda_sync_ff, nxt_scl_sync, nxt_sda_sync;
    logic [7:0] scl_cnt_ff, sda_cnt_ff, nxt_scl_cnt, nxt_sda_cnt;
    logic scl_ff, sda_ff, nxt_scl, nxt_sda;
    logic scl_prev_ff, sda_prev_ff;

    function automatic logic [7:0] filt_count(input logic agree, input logic differs, input logic [7:0] cnt);
        if (!agree || !differs) begin
            filt_count = 8'h00;
        end else begin
            filt_count = cnt + 8'h01;
        end
    endfunction : filt_count

    always_comb begin
        nxt_scl_sync = {scl_sync_ff[1:0], scl_in};
        nxt_sda_sync = {sda_sync_ff[1:0], sda_in};
        nxt_scl_cnt = filt_count(scl_sync_ff[1] == scl_sync_ff[2], scl_sync_ff[2] != scl_ff, scl_cnt_ff);
        nxt_sda_cnt = filt_count(sda_sync_ff[1] == sda_sync_ff[2], sda_sync_ff[2] != sda_ff, sda_cnt_ff);
        nxt_scl = scl_ff;
        nxt_sda = sda_ff;
        if (nxt_scl_cnt >= 8'(FILT_CYCLES)) begin
            nxt_scl = scl_sync_ff[2];
            nxt_scl_cnt = 8'h00;
        end
        if (nxt_sda_cnt >= 8'(FILT_CYCLES)) begin
            nxt_sda = sda_sync_ff[2];
            nxt_sda_cnt = 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            scl_cnt_ff <= 8'h00;
            sda_cnt_ff <= 8'h00;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_sync_ff <= nxt_scl_sync;
            sda_sync_ff <= nxt_sda_sync;
            scl_cnt_ff <= nxt_scl_cnt;
            sda_cnt_ff <= nxt_sda_cnt;
            scl_ff <= nxt_scl;
            sda_ff <= nxt_sda;
            scl_prev_ff <= scl_ff;
            sda_prev_ff <= sda_ff;
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;
    always_comb begin
        scl_rise = scl_ff && !scl_prev_ff;
        scl_fall = !scl_ff && scl_prev_ff;
        start_seen = scl_ff && scl_prev_ff && !sda_ff && sda_prev_ff;
        stop_seen = scl_ff && scl_prev_ff && sda_ff && !sda_prev_ff;
    end

    // ************************************************
    // strap pins
    // ************************************************
    logic [2:0] strap_meta_ff, strap_mid_ff, strap_last_ff, strap_ff, nxt_strap;

    always_comb begin
        nxt_strap = strap_ff;
        if (strap_mid_ff == strap_last_ff) begin
            nxt_strap = strap_last_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            strap_meta_ff <= 3'h0;
            strap_mid_ff <= 3'h0;
            strap_last_ff <= 3'h0;
            strap_ff <= 3'h0;
        end else begin
            strap_meta_ff <= straps.strap;
            strap_mid_ff <= strap_meta_ff;
            strap_last_ff <= strap_mid_ff;
            strap_ff <= nxt_strap;
        end
    end

    // ************************************************
    // address phase
    // ************************************************
    phase_type phase_ff, nxt_phase;
    logic [7:0] shift_ff, nxt_shift;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    match_type nxt_match;
    logic sda_oe_ff, nxt_sda_oe;
    logic nxt_busy;
    logic [6:0] own_addr;

    // same value for read and write addressing
    always_comb begin
        own_addr = `BASE_SLAVE_ADDR + {4'h0, strap_ff};
    end

    always_comb begin
        nxt_phase = phase_ff;
        nxt_shift = shift_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_match = match_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_busy = busy_ff;
        if (start_seen) begin
            nxt_phase = ST_ADDR;
            nxt_bit_cnt = 4'h0;
            nxt_match = '0;
            nxt_sda_oe = 1'b0;
            nxt_busy = 1'b1;
        end else if (stop_seen) begin
            nxt_phase = ST_IDLE;
            nxt_match = '0;
            nxt_sda_oe = 1'b0;
            nxt_busy = 1'b0;
        end else begin
            unique case (phase_ff)
                ST_IDLE: begin
                    nxt_sda_oe = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[6:0], sda_ff};
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end
                    if (scl_fall && bit_cnt_ff == `BYTE_BITS) begin
                        if (shift_ff[7:1] == own_addr) begin
                            nxt_sda_oe = 1'b1;
                            nxt_phase = ST_ACK;
                            nxt_match.dir_read = shift_ff[0];
                            nxt_match.selected = 1'b1;
                        end else begin
                            nxt_phase = ST_SKIP;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        nxt_sda_oe = 1'b0;
                        nxt_phase = ST_XFER;
                    end
                end
                ST_XFER: begin
                    nxt_sda_oe = 1'b0;
                end
                ST_SKIP: begin
                    nxt_sda_oe = 1'b0;
                end
                default: begin
                    nxt_phase = ST_IDLE;
                    nxt_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_ff <= ST_IDLE;
            shift_ff <= 8'h00;
            bit_cnt_ff <= 4'h0;
            match_ff <= '0;
            sda_oe_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            shift_ff <= nxt_shift;
            bit_cnt_ff <= nxt_bit_cnt;
            match_ff <= nxt_match;
            sda_oe_ff <= nxt_sda_oe;
            busy_ff <= nxt_busy;
        end
    end

    always_comb begin
        sda_out = 1'b0;
        sda_oe = sda_oe_ff;
    end

    // ************************************************
    // checks
    // ************************************************
    AST_NO_DRIVE_SKIP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        phase_ff == ST_SKIP |-> !sda_oe_ff) else $error("drove bus after mismatch");
    AST_ACK_ON_MATCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(sda_oe_ff) |-> match_ff.selected && match_ff.dir_read == shift_ff[0])
        else $error("ack without match");
    AST_ACK_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(sda_oe_ff) |-> shift_ff[7:1] == `BASE_SLAVE_ADDR + {4'h0, straps.strap}) else $error("wrong address");
    AST_ADDR_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        own_addr >= `BASE_SLAVE_ADDR && own_addr <= `LAST_SLAVE_ADDR) else $error("address out of range");
    AST_DIR_BIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(match_ff.selected) |-> match_ff.dir_read == $past(shift_ff[0])) else $error("direction wrong");
    AST_IDLE_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
        phase_ff == ST_IDLE && !start_seen |=> phase_ff == ST_IDLE) else $error("left idle without start");
    AST_STOP_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stop_seen && !start_seen |=> phase_ff == ST_IDLE && !busy_ff && !sda_oe_ff) else $error("stop ignored");
    AST_SHIFT_RISE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        phase_ff == ST_ADDR && !scl_rise && !start_seen && !stop_seen |=> $stable(shift_ff))
        else $error("shift without clock rise");
    AST_FILTER: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(scl_ff) |-> $past(scl_sync_ff[2]) == scl_ff && $past(scl_cnt_ff) == 8'(FILT_CYCLES - 1))
        else $error("filter bypassed");
    AST_ACK_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        phase_ff == ST_ACK && scl_fall && !start_seen && !stop_seen |=> !sda_oe_ff)
        else $error("ack held too long");
    AST_SYNC_AGREE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(sda_ff) |-> $past(sda_sync_ff[1]) == $past(sda_sync_ff[2]) && $past(sda_sync_ff[2]) == sda_ff)
        else $error("data line taken before settled");

endmodule : i2c_slave_address_match

// file: bench/i2c_master_model.sv
// bus master model for the serial clock and data lines
`timescale 1ns/1ps
module i2c_master_model (
    // clock
    input wire logic clk_sys,
    // bus lines
    input wire logic sda_line,
    output logic scl_out,
    output logic sda_low
);
    // half of an 80 ns bus clock period
    localparam int HALF = 5;
    initial begin
        scl_out = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic put_bit(input logic b, output logic seen);
        tick(1);
        sda_low <= ~b;
        tick(HALF - 1);
        scl_out <= 1'b1;
        tick(HALF - 1);
        seen = sda_line;
        tick(1);
        scl_out <= 1'b0;
    endtask : put_bit
    task automatic start();
        tick(1);
        if (scl_out === 1'b0) begin
            sda_low <= 1'b0;
            tick(HALF - 1);
            scl_out <= 1'b1;
            tick(HALF);
        end
        sda_low <= 1'b1;
        tick(HALF);
        scl_out <= 1'b0;
    endtask : start
    task automatic stop();
        tick(1);
        sda_low <= 1'b1;
        tick(HALF - 1);
        scl_out <= 1'b1;
        tick(HALF);
        sda_low <= 1'b0;
        tick(HALF);
    endtask : stop
    // address then direction, ninth bit released
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte
endmodule : i2c_master_model

// file: bench/i2c_slave_address_match_bench.sv
// self checking bench for the slave address front end
`timescale 1ns/1ps
`include "addr_match_defs.svh"
module i2c_slave_address_match_bench;
    import addr_match_pkg::*;
    logic clk_sys;
    logic rst_n;
    strap_type straps;
    logic scl_line;
    logic sda_low;
    logic sda_line;
    logic sda_out;
    logic sda_oe;
    match_type match_ff;
    logic busy_ff;
    logic ack;
    int err_count;
    int n_compared;
    // open drain data line with pull up
    assign sda_line = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    i2c_slave_address_match #(.FILT_CYCLES(1)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .straps(straps),
        .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .match_ff(match_ff),
        .busy_ff(busy_ff));
    i2c_master_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl_out(scl_line), .sda_low(sda_low));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [1:0] seen, input logic [1:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : check
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic test_glitch();
        host.sda_low <= 1'b1;
        host.tick(1);
        host.sda_low <= 1'b0;
        host.tick(20);
        check(busy_ff, 1'b0, "glitch seen as start");
        host.sda_low <= 1'b1;
        host.tick(12);
        check(busy_ff, 1'b1, "start missed");
        host.stop();
        host.tick(10);
        check(busy_ff, 1'b0, "stop missed");
        $display("test_glitch done");
    endtask : test_glitch
    task automatic test_nostart();
        host.scl_out <= 1'b0;
        host.tick(5);
        host.send_byte({`BASE_SLAVE_ADDR, 1'b0}, ack);
        host.tick(1);
        host.scl_out <= 1'b1;
        host.tick(10);
        check({ack, busy_ff}, 2'b00, "answered without start");
        $display("test_nostart done");
    endtask : test_nostart
    task automatic test_match();
        for (int s = 0; s < 8; s++) begin
            for (int rw = 0; rw < 2; rw++) begin
                straps <= '{strap: 3'(s)};
                host.tick(2);
                host.start();
                host.send_byte({`BASE_SLAVE_ADDR + 7'(s), 1'(rw)}, ack);
                check(ack, 1'b1, "no ack on own address");
                check(sda_out, 1'b0, "ack level not low");
                check(match_ff, {1'(rw), 1'b1}, "match state");
                check(busy_ff, 1'b1, "not busy");
                host.stop();
                host.tick(10);
                check({busy_ff, match_ff.selected}, 2'b00, "not idle after stop");
            end
        end
        $display("test_match done");
    endtask : test_match
    task automatic test_mismatch();
        logic [6:0] wrong [3] = '{7'h44, 7'h46, 7'h4A};
        straps <= '{strap: 3'h3};
        foreach (wrong[i]) begin
            host.tick(2);
            host.start();
            host.send_byte({wrong[i], 1'b0}, ack);
            check({ack, match_ff.selected}, 2'b00, "ack on foreign address");
            host.send_byte({7'h45, 1'b0}, ack);
            check(ack, 1'b0, "drive after mismatch");
            host.start();
            host.send_byte({7'h45, 1'b1}, ack);
            check(ack, 1'b1, "no ack after restart");
            host.stop();
        end
        $display("test_mismatch done");
    endtask : test_mismatch
    initial begin
        rst_n = 1'b0;
        straps = '{strap: 3'h0};
        err_count = 0;
        n_compared = 0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        host.tick(8);
        test_glitch();
        test_nostart();
        test_match();
        test_mismatch();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : i2c_slave_address_match_bench
